// ---- hw/afli_pkg.sv ----
// constants for the arc fault latch and indicator block
`default_nettype none
package afli_pkg;
	localparam int unsigned CLK_HZ            = 40000000;
	localparam int unsigned SELFTEST_MIN_MS   = 10;
	localparam int unsigned SELFTEST_CYCLES   = (CLK_HZ / 1000) * SELFTEST_MIN_MS;
	localparam int unsigned BLINK_PERIOD_MS   = 1000;
	localparam int unsigned BLINK_HALF_CYCLES = (CLK_HZ / 1000) * BLINK_PERIOD_MS / 2;
	localparam int unsigned CNT_W             = 25;
	localparam logic        LATCH_RST         = 1'b0;
endpackage : afli_pkg
`default_nettype wire

// ---- hw/afli_sync.sv ----
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
`default_nettype none
module afli_sync
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// pin and result
	input  wire logic pin_i,
	output var  logic level_o
);
	logic s1;
	logic s2;
	logic s3;
	wire  agree = (s2 == s3);

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1      <= 1'b1;
			s2      <= 1'b1;
			s3      <= 1'b1;
			level_o <= 1'b1;
		end
		else
		begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
			if (agree)
				level_o <= s3;
		end
	end
endmodule : afli_sync
`default_nettype wire

// ---- hw/afli_top.sv ----
// fault latch, open-collector fault output and status indicator
`timescale 1ns/1ps
`default_nettype none
module afli_top
#(
	parameter int unsigned SELFTEST_CYCLES   = afli_pkg::SELFTEST_CYCLES,
	parameter int unsigned BLINK_HALF_CYCLES = afli_pkg::BLINK_HALF_CYCLES
)
(
	// clock and power-on reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// self-test pin, active low
	input  wire logic selftest_n_i,
	// detection events from sensing logic (same clock)
	input  wire logic arc_detect_i,
	input  wire logic det_fault_i,
	// open-collector fault output
	output var  logic fault_oe_o,
	output var  logic fault_o,
	// status indicator and latch state
	output var  logic led_o,
	output var  logic latched_o
);
	// ------------------------------------------------------------
	// self-test qualification
	// ------------------------------------------------------------
	logic                    st_level;
	logic [afli_pkg::CNT_W-1:0] st_cnt;
	logic [afli_pkg::CNT_W-1:0] next_st_cnt;
	logic [afli_pkg::CNT_W-1:0] blink_cnt;
	logic [afli_pkg::CNT_W-1:0] next_blink_cnt;
	logic                    latch;
	logic                    blink;

	afli_sync u_sync
	(
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (selftest_n_i),
		.level_o(st_level)
	);

	wire st_low   = ~st_level;
	wire st_done  = st_low && (st_cnt == afli_pkg::CNT_W'(SELFTEST_CYCLES - 1));
	assign next_st_cnt = !st_low ? '0 : (st_done ? st_cnt : st_cnt + 1'b1);
	wire fault_evt = arc_detect_i | det_fault_i | st_done;

	// ------------------------------------------------------------
	// blink timebase
	// ------------------------------------------------------------
	wire blink_wrap = (blink_cnt == afli_pkg::CNT_W'(BLINK_HALF_CYCLES - 1));
	assign next_blink_cnt = blink_wrap ? '0 : blink_cnt + 1'b1;

	// ------------------------------------------------------------
	// latch and outputs
	// ------------------------------------------------------------
	wire next_latch = latch | fault_evt;
	wire next_led   = next_latch ? 1'b1 : (blink_wrap ? ~blink : blink);

	// ------------------------------------------------------------
	// self-test and timebase registers
	// ------------------------------------------------------------

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_cnt <= '0;
		end
		else
		begin
			st_cnt <= next_st_cnt;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			blink_cnt <= '0;
		end
		else
		begin
			blink_cnt <= next_blink_cnt;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			blink <= 1'b0;
		end
		else
		begin
			blink <= blink_wrap ? ~blink : blink;
		end
	end

	// ------------------------------------------------------------
	// latch registers
	// ------------------------------------------------------------

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			latch <= afli_pkg::LATCH_RST;
		end
		else
		begin
			latch <= next_latch;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			latched_o <= afli_pkg::LATCH_RST;
		end
		else
		begin
			latched_o <= next_latch;
		end
	end

	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			fault_oe_o <= 1'b1;
			fault_o    <= 1'b0;
		end
		else
		begin
			fault_oe_o <= ~next_latch;
			fault_o    <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			led_o <= 1'b0;
		end
		else
		begin
			led_o <= next_led;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_ST_FAULT: assert property (st_done |=> !fault_oe_o && latched_o)
		else $error("qualified self test did not set fault");
	AST_ST_STICKY: assert property ($rose(latched_o) |=> latched_o [*8])
		else $error("latch dropped after fault");
	AST_NORMAL_LOW: assert property (!latched_o |-> fault_oe_o && !fault_o)
		else $error("fault output not conducting while normal");
	AST_ARC_OPEN: assert property (arc_detect_i || det_fault_i |=> !fault_oe_o)
		else $error("fault output not released on fault");
	AST_BLINK: assert property (!latched_o && blink_wrap ##1 !latched_o |-> led_o != $past(led_o))
		else $error("indicator not toggling in normal state");
	AST_SOLID: assert property (latched_o |-> led_o)
		else $error("indicator not steady on in fault");
	AST_HOLD: assert property (latched_o && !arc_detect_i |=> latched_o && !fault_oe_o)
		else $error("fault state lost after arcing stopped");
	AST_SHORT_IGN: assert property (!latched_o && !st_done && !arc_detect_i && !det_fault_i |=> !latched_o)
		else $error("latch set without a cause");

	AST_FO_ZERO: assert property (!fault_o)
		else $error("fault output value not low");

	AST_OE_TRACK: assert property (fault_oe_o == !latched_o)
		else $error("fault output enable disagrees with latch");

	AST_ST_RESTART: assert property (!st_low |=> st_cnt == '0)
		else $error("self-test counter not restarted on high pin");

	AST_ST_COUNT: assert property (st_low && !st_done |=> st_cnt == $past(st_cnt) + 1'b1)
		else $error("self-test counter not advancing while pin low");

	AST_LED_STILL: assert property (!latched_o && !blink_wrap ##1 !latched_o |-> $stable(led_o))
		else $error("indicator changed between blink steps");

	AST_TRIP_SHOW: assert property ($rose(latched_o) |-> led_o && !fault_oe_o)
		else $error("fault entry without steady indicator and open output");

	AST_WRAP_ZERO: assert property (blink_wrap |=> blink_cnt == '0)
		else $error("blink timebase did not wrap");

	AST_DET_LATCH: assert property (det_fault_i |=> latched_o)
		else $error("detector fault did not latch");

	AST_LATCH_MATCH: assert property (latch == latched_o)
		else $error("latch state output disagrees with latch");

	// ------------------------------------------------------------
	// cover points
	// ------------------------------------------------------------
	COV_SELFTEST: cover property (st_done ##1 latched_o);
	COV_ARC: cover property (!latched_o ##1 arc_detect_i ##1 latched_o);
	COV_BLINK: cover property (!latched_o && blink_wrap);
	COV_DET: cover property (!latched_o ##1 det_fault_i ##1 latched_o);
	COV_SHORT: cover property (st_low ##1 !st_low && !latched_o);
endmodule : afli_top
`default_nettype wire

// ---- tb/afli_ctrl_model.sv ----
// string control side: reads the fault line, pulses the self-test pin
`timescale 1ns/1ps
`default_nettype none
module afli_ctrl_model
(
	// clock
	input  wire logic       clk_i,
	// fault line from the block
	input  wire logic       fault_oe_i,
	input  wire logic       fault_i,
	// bench control
	input  wire logic       go_i,
	input  wire logic [7:0] hold_i,
	// pins towards the block and trip result
	output wire logic       selftest_n_o,
	output wire logic       trip_o
);
	logic [7:0] left = 8'h00;
	// pulled up while the transistor is off
	assign trip_o = fault_oe_i ? fault_i : 1'b1;
	always @(posedge clk_i)
		if (go_i)
			left <= hold_i;
		else if (left != 8'h00)
			left <= left - 8'h01;
	assign selftest_n_o = (left == 8'h00);
endmodule : afli_ctrl_model
`default_nettype wire

// ---- tb/tb.sv ----
// bench for the fault latch block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 0, rst = 1, arc = 0, det = 0, go = 0;
	logic [7:0] hold = 8'h00;
	wire logic st_n, oe, fo, led, lat, trip;
	int fail_count = 0, compares = 0, seed = 32'had620476, k, i;
	always #12.5 clk = ~clk;
	afli_top #(.SELFTEST_CYCLES(16), .BLINK_HALF_CYCLES(8)) dut (.clk_i(clk), .rst_i(rst),
		.selftest_n_i(st_n), .arc_detect_i(arc), .det_fault_i(det), .fault_oe_o(oe),
		.fault_o(fo), .led_o(led), .latched_o(lat));
	afli_ctrl_model ctrl (.clk_i(clk), .fault_oe_i(oe), .fault_i(fo), .go_i(go),
		.hold_i(hold), .selftest_n_o(st_n), .trip_o(trip));
	task chk(input string n, input logic e, input logic g);
		compares++;
		if (g !== e)
		begin
			fail_count++;
			$display("mismatch %s exp %b got %b", n, e, g);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task por;
		rst <= 1;
		cyc(4);
		rst <= 0;
		cyc(1);
	endtask : por
	// self-test request of n cycles low, then settle
	task stest(input int n);
		hold <= n[7:0];
		go <= 1;
		cyc(1);
		go <= 0;
		cyc(60);
		@(negedge clk);
	endtask : stest
	task give_verdict;
		$display("errors %0d of %0d compares", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	initial
	begin
		#50us;
		fail_count++;
		give_verdict();
	end
	initial
	begin
		por();
		@(negedge clk);
		chk("trip", 0, trip);
		k = led;
		cyc(8);
		@(negedge clk);
		chk("blink", !k[0], led);
		stest(1 + $unsigned($random(seed)) % 10);
		chk("short", 0, lat);
		stest(15);
		chk("edge", 0, lat);
		stest(20 + $unsigned($random(seed)) % 30);
		chk("stlat", 1, lat);
		chk("sttrip", 1, trip);
		cyc(9);
		@(negedge clk);
		chk("steady", 1, led);
		for (i = 0; i < 2; i++)
		begin
			por();
			@(negedge clk);
			chk("clear", 0, lat);
			chk("clrtrip", 0, trip);
			cyc(1 + $unsigned($random(seed)) % 16);
			arc <= (i == 0);
			det <= (i == 1);
			cyc(1);
			arc <= 0;
			det <= 0;
			cyc(20);
			@(negedge clk);
			chk("trip", 1, trip);
			chk("led", 1, led);
		end
		por();
		@(negedge clk);
		chk("clear", 0, lat);
		give_verdict();
	end
endmodule : tb
`default_nettype wire
